/* vimc_pkg.sv */
package vimc_pkg;

  // System-register selector fields
  localparam logic [1:0] OP0_SEL       = 2'h3;
  localparam logic [2:0] OP1_SEL       = 3'h4;
  localparam logic [3:0] CRN_SEL       = 4'hC;
  localparam logic [3:0] CRM_SEL       = 4'hB;
  localparam logic [2:0] OP2_STATUS    = 3'h2;
  localparam logic [2:0] OP2_CONTROL   = 3'h7;

  // Outcome codes
  localparam logic [5:0] TRAP_CLASS    = 6'h18;
  localparam logic [11:0] REDIRECT_OFS = 12'h04C8;

  // Control register field positions
  localparam int PMR_LSB   = 24;
  localparam int BP0_LSB   = 21;
  localparam int BP1_LSB   = 18;
  localparam int SPLIT_BIT = 9;
  localparam int CBP_BIT   = 4;
  localparam int FIQ_BIT   = 3;
  localparam int ACK_BIT   = 2;
  localparam int EN1_BIT   = 1;
  localparam int EN0_BIT   = 0;

  // Reset values of the control fields, binary point maximum and spurious ID
  localparam logic [7:0] PMR_RST = 8'h00;
  localparam logic [2:0] BP_RST  = 3'h0;
  localparam logic [2:0] BP_MAX  = 3'h7;
  localparam logic [15:0] SPURIOUS_ID = 16'h03FE;

  localparam int NUM_LR = 16;

  // Privilege levels
  typedef enum logic [1:0] {
    VIMC_EL_USER  = 2'b00,
    VIMC_EL_GUEST = 2'b01,
    VIMC_EL_HYP   = 2'b10,
    VIMC_EL_MON   = 2'b11
  } vimc_el_t;

  // Access outcome
  typedef enum logic [1:0] {
    VIMC_RES_OK       = 2'b00,
    VIMC_RES_UNDEF    = 2'b01,
    VIMC_RES_TRAP     = 2'b10,
    VIMC_RES_REDIRECT = 2'b11
  } vimc_res_t;

  // One system-register access request
  typedef struct packed {
    logic        valid;
    logic        write;
    logic [1:0]  op0;
    logic [2:0]  op1;
    logic [3:0]  crn;
    logic [3:0]  crm;
    logic [2:0]  op2;
    vimc_el_t    el;
    logic        secure;
    logic [63:0] wdata;
  } vimc_req_t;

  // Answer to the core
  typedef struct packed {
    logic        valid;
    vimc_res_t   result;
    logic [5:0]  trap_class;
    logic        trap_to_mon;
    logic [11:0] redirect_ofs;
    logic [63:0] rdata;
  } vimc_rsp_t;

  // Hypervisor enables and miss counter feeding the status flags
  typedef struct packed {
    logic       grp_one_off_irq_en;
    logic       grp_one_on_irq_en;
    logic       grp_zero_off_irq_en;
    logic       grp_zero_on_irq_en;
    logic       none_pending_irq_en;
    logic       missing_entry_irq_en;
    logic       list_low_irq_en;
    logic [4:0] deactivation_miss_counter;
  } vimc_hyp_t;

endpackage

/* vimc_ctrl.sv */
`timescale 1ns/1ps

// Function
// R1: Bit 7 set when group-one-off enable set and guest group one disabled.
// R2: Bit 6 set when group-one-on enable set and guest group one enabled.
// R3: Bit 5 set when group-zero-off enable set and guest group zero disabled.
// R4: Bit 4 set when group-zero-on enable set and guest group zero enabled.
// R5: Bit 3 set when none-pending enable set and no entry is pending.
// R6: Bit 2 set when missing-entry enable set and miss counter non-zero.
// R7: Bit 1 set when list-low enable set and at most one valid entry.
// R8: Bit 0 set when any per-entry end-of-interrupt status bit is set.
// R9: Status flags reset to zero; bits 63 to 8 read zero.
// R10: List-low and none-pending ignore directly injected interrupts.
// R11: Priority mask passes only interrupts of higher priority than it.
// R12: Group-zero binary point clamps writes to the preemption-derived minimum.
// R13: Non-secure group-one binary point clamps to group-zero minimum plus one.
// R14: Secure group-one binary point clamps to the group-zero minimum.
// R15: Hypervisor accesses always reach group-one binary point.
// R16: Split mode selects priority drop only versus drop plus deactivate.
// R17: Common binary point: guest reads group-zero plus one saturated, writes ignored.
// R18: Fast-route bit steers group zero to FIQ; fixed one when always-enabled. Here the stored bit resets to zero and reads zero until first written.
// R19: Ack-control zero returns ID 1022 for group one; fixed zero when always-enabled.
// R20: Bits 1 and 0 enable guest group one and group zero.
// R21: Status and control reached at fixed selector encodings.
// R22: User access undefined; disabled hypervisor or monitor access traps 0x18.
// R23: Nested guest control reads redirect to offset 0x4C8.
// R24: Each list entry has two-bit state: invalid, pending, active, both.
// R25: Status read-only, recomputed live; maintenance output ORs all flags.
// R26: Reserved control bits read zero and ignore writes.
module vimc_ctrl #(
  parameter logic [2:0] PREEMPT_BITS = 3'h4,
  parameter bit         SRE_FIXED    = 1'b0
) (
  input  wire logic                             clk,
  input  wire logic                             resetn,
  input  wire vimc_pkg::vimc_req_t              req,
  output vimc_pkg::vimc_rsp_t                   rsp,
  input  wire vimc_pkg::vimc_hyp_t              hyp,
  input  wire logic [2*vimc_pkg::NUM_LR-1:0]    lr_state,
  input  wire logic [vimc_pkg::NUM_LR-1:0]      per_entry_eoi_status,
  input  wire logic                             sre_hyp,
  input  wire logic                             sre_mon,
  input  wire logic                             nested_en,
  input  wire logic                             nested_mem_en,
  input  wire logic                             pend_valid,
  input  wire logic [7:0]                       pend_priority,
  input  wire logic                             pend_group_one,
  input  wire logic [15:0]                      pend_id,
  input  wire logic                             guest_bp1_rd,
  input  wire logic                             guest_bp1_wr,
  input  wire logic [2:0]                       guest_bp1_wdata,
  output logic                                  maint_irq,
  output logic                                  virq,
  output logic                                  vfiq,
  output logic [15:0]                           ack_id,
  output logic [2:0]                            guest_bp1_rdata,
  output logic                                  eoi_deactivates,
  output logic                                  deactivate_reg_active
);

  logic        rst_meta_reg;
  logic        rst_sync_reg;
  logic [7:0]  pmr_reg;
  logic [2:0]  bp0_reg;
  logic [2:0]  bp1_reg;
  logic        split_reg;
  logic        cbp_reg;
  logic        fiq_reg;
  logic        ack_reg;
  logic        en1_reg;
  logic        en0_reg;
  vimc_pkg::vimc_rsp_t rsp_reg;
  vimc_pkg::vimc_rsp_t rsp_next;

  // Reset release through two flops
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rst_meta_reg <= 1'b0;
      rst_sync_reg <= 1'b0;
    end else begin
      rst_meta_reg <= 1'b1;
      rst_sync_reg <= rst_meta_reg;
    end
  end

  // Count of entries by state; pure list contents, no direct injection
  function automatic logic [4:0] count_state(input logic [2*vimc_pkg::NUM_LR-1:0] st,
                                             input logic pend_only);
    logic [4:0] n;
    n = 5'h0;
    for (int i = 0; i < vimc_pkg::NUM_LR; i++) begin
      if (pend_only ? st[2*i] : (st[2*i +: 2] != 2'b00)) // R24
        n = n + 5'h1;
    end
    return n;
  endfunction

  // Clamp a binary point to a minimum
  function automatic logic [2:0] clamp_bp(input logic [2:0] v, input logic [2:0] mn);
    return (v < mn) ? mn : v;
  endfunction

  // Minimum binary points derived from preemption bits
  wire logic [2:0] bp0_min   = 3'(3'h7 - PREEMPT_BITS - 3'h1);                 // R12
  wire logic [2:0] bp1_min_n = (bp0_min == vimc_pkg::BP_MAX) ? bp0_min
                               : 3'(bp0_min + 3'h1);                           // R13
  wire logic [2:0] bp1_min   = req.secure ? bp0_min : bp1_min_n;              // R14

  // Entry counts feeding the list flags
  wire logic [4:0] n_pend  = count_state(lr_state, 1'b1);                     // R10
  wire logic [4:0] n_valid = count_state(lr_state, 1'b0);                     // R10

  // Live status word
  wire logic [7:0] status_bits = {
    hyp.grp_one_off_irq_en   & ~en1_reg,                                      // R1
    hyp.grp_one_on_irq_en    &  en1_reg,                                      // R2
    hyp.grp_zero_off_irq_en  & ~en0_reg,                                      // R3
    hyp.grp_zero_on_irq_en   &  en0_reg,                                      // R4
    hyp.none_pending_irq_en  & (n_pend == 5'h0),                              // R5
    hyp.missing_entry_irq_en & (hyp.deactivation_miss_counter != 5'h0),       // R6
    hyp.list_low_irq_en      & (n_valid <= 5'h1),                             // R7
    |per_entry_eoi_status                                                     // R8
  };
  // Flags forced low until the reset release completes
  wire logic [7:0]  grp_flags  = rst_sync_reg ? status_bits : 8'h00;          // R9
  wire logic [63:0] status_word = {56'h0, grp_flags};                         // R9 R25

  // Assembled control word; reserved bits stay zero
  wire logic [63:0] ctrl_word = {32'h0, pmr_reg, bp0_reg, bp1_reg, 8'h00,
                                 split_reg, 4'h0, cbp_reg, fiq_reg,
                                 ack_reg, en1_reg, en0_reg};                  // R26

  // Selector decode
  wire logic sel_base = req.valid && (req.op0 == vimc_pkg::OP0_SEL)
                        && (req.op1 == vimc_pkg::OP1_SEL)
                        && (req.crn == vimc_pkg::CRN_SEL)
                        && (req.crm == vimc_pkg::CRM_SEL);                    // R21
  wire logic sel_stat = sel_base && (req.op2 == vimc_pkg::OP2_STATUS);        // R21
  wire logic sel_ctrl = sel_base && (req.op2 == vimc_pkg::OP2_CONTROL);       // R21
  wire logic sel_any  = sel_stat || sel_ctrl;

  // Privilege check
  wire logic at_hyp   = (req.el == vimc_pkg::VIMC_EL_HYP);
  wire logic at_mon   = (req.el == vimc_pkg::VIMC_EL_MON);
  wire logic at_guest = (req.el == vimc_pkg::VIMC_EL_GUEST);
  wire logic sre_ok   = (at_hyp && sre_hyp) || (at_mon && sre_mon);
  wire logic redirect = at_guest && nested_en && nested_mem_en && sel_ctrl;   // R23
  wire logic g_trap   = at_guest && nested_en && !redirect;
  wire logic h_trap   = (at_hyp && !sre_hyp) || (at_mon && !sre_mon);         // R22
  wire logic do_write = sel_ctrl && req.write && sre_ok;
  // Status is read-only: writes to it are dropped
  wire logic [63:0] wd = req.wdata;

  // Next answer
  always_comb begin
    rsp_next = '0;
    rsp_next.valid = sel_any;
    if (req.el == vimc_pkg::VIMC_EL_USER) begin
      rsp_next.result = vimc_pkg::VIMC_RES_UNDEF;                             // R22
    end else if (redirect) begin
      rsp_next.result       = vimc_pkg::VIMC_RES_REDIRECT;                    // R23
      rsp_next.redirect_ofs = vimc_pkg::REDIRECT_OFS;
    end else if (g_trap || h_trap) begin
      rsp_next.result      = vimc_pkg::VIMC_RES_TRAP;                         // R22
      rsp_next.trap_class  = vimc_pkg::TRAP_CLASS;
      rsp_next.trap_to_mon = at_mon;
    end else if (at_guest) begin
      rsp_next.result = vimc_pkg::VIMC_RES_UNDEF;
    end else begin
      rsp_next.result = vimc_pkg::VIMC_RES_OK;
      rsp_next.rdata  = sel_stat ? status_word : ctrl_word;                   // R25
    end
  end

  // Control register storage; hypervisor writes always reach both points
  always_ff @(posedge clk or negedge rst_sync_reg) begin
    if (!rst_sync_reg) begin
      pmr_reg   <= vimc_pkg::PMR_RST;
      bp0_reg   <= vimc_pkg::BP_RST;
      bp1_reg   <= vimc_pkg::BP_RST;
      split_reg <= 1'b0;
      cbp_reg   <= 1'b0;
      fiq_reg   <= 1'b0;
      ack_reg   <= 1'b0;
      en1_reg   <= 1'b0;
      en0_reg   <= 1'b0;
    end else if (do_write) begin
      pmr_reg   <= wd[vimc_pkg::PMR_LSB +: 8];
      bp0_reg   <= clamp_bp(wd[vimc_pkg::BP0_LSB +: 3], bp0_min);             // R12
      bp1_reg   <= clamp_bp(wd[vimc_pkg::BP1_LSB +: 3], bp1_min);             // R13 R14 R15
      split_reg <= wd[vimc_pkg::SPLIT_BIT];
      cbp_reg   <= wd[vimc_pkg::CBP_BIT];
      fiq_reg   <= SRE_FIXED ? 1'b1 : wd[vimc_pkg::FIQ_BIT];                  // R18
      ack_reg   <= SRE_FIXED ? 1'b0 : wd[vimc_pkg::ACK_BIT];                  // R19
      en1_reg   <= wd[vimc_pkg::EN1_BIT];                                     // R20
      en0_reg   <= wd[vimc_pkg::EN0_BIT];                                     // R20
    end else if (guest_bp1_wr && !cbp_reg) begin
      // Guest writes are non-secure; ignored under common point
      bp1_reg   <= clamp_bp(guest_bp1_wdata, bp1_min_n);                      // R17
    end
  end

  // Answer register
  always_ff @(posedge clk or negedge rst_sync_reg) begin
    if (!rst_sync_reg)
      rsp_reg <= '0;
    else
      rsp_reg <= rsp_next;
  end
  assign rsp = rsp_reg;

  // Guest-facing view
  wire logic [2:0] bp0_plus = (bp0_reg == vimc_pkg::BP_MAX) ? vimc_pkg::BP_MAX
                              : 3'(bp0_reg + 3'h1);
  wire logic above_mask = pend_valid && (pend_priority < pmr_reg);             // R11
  wire logic grp_on     = pend_group_one ? en1_reg : en0_reg;                  // R20
  wire logic signal     = above_mask && grp_on;
  wire logic fast_path  = signal && !pend_group_one && (fiq_reg || SRE_FIXED); // R18

  assign maint_irq             = |grp_flags;                                   // R25
  assign virq                  = signal && !fast_path;                         // R18
  assign vfiq                  = fast_path;                                    // R18
  assign ack_id                = (pend_group_one && !ack_reg)
                                 ? vimc_pkg::SPURIOUS_ID : pend_id;            // R19
  // Guest view driven only while a guest read is in progress
  wire logic [2:0] bp1_view    = cbp_reg ? bp0_plus : bp1_reg;                 // R17
  assign guest_bp1_rdata       = guest_bp1_rd ? bp1_view : 3'h0;               // R17
  assign eoi_deactivates       = !split_reg;                                   // R16
  assign deactivate_reg_active = split_reg;                                    // R16

  // Checks
  a_grp_one_off: assert property (@(posedge clk) disable iff (!rst_sync_reg)
    grp_flags[7] == (hyp.grp_one_off_irq_en && !en1_reg))
    else $error("group one off flag wrong"); // R1
  a_grp_one_on: assert property (@(posedge clk) disable iff (!rst_sync_reg)
    grp_flags[6] == (hyp.grp_one_on_irq_en && en1_reg))
    else $error("group one on flag wrong"); // R2
  a_grp_zero_off: assert property (@(posedge clk) disable iff (!rst_sync_reg)
    grp_flags[5] == (hyp.grp_zero_off_irq_en && !en0_reg))
    else $error("group zero off flag wrong"); // R3
  a_grp_zero_on: assert property (@(posedge clk) disable iff (!rst_sync_reg)
    grp_flags[4] == (hyp.grp_zero_on_irq_en && en0_reg))
    else $error("group zero on flag wrong"); // R4
  a_missing_entry: assert property (@(posedge clk) disable iff (!rst_sync_reg)
    grp_flags[2] == (hyp.missing_entry_irq_en && (hyp.deactivation_miss_counter != 5'h0)))
    else $error("missing entry flag wrong"); // R6
  a_eoi_flag: assert property (@(posedge clk) disable iff (!rst_sync_reg)
    grp_flags[0] == (per_entry_eoi_status != 16'h0))
    else $error("end of irq flag wrong"); // R8
  a_status_read: assert property (@(posedge clk) disable iff (!rst_sync_reg)
    sel_stat && sre_ok && !req.write |=> rsp.valid && rsp.rdata[63:8] == 56'h0
                                         && rsp.rdata[7:0] == $past(grp_flags))
    else $error("status read data wrong"); // R9
  a_user_undef: assert property (@(posedge clk) disable iff (!rst_sync_reg)
    sel_any && req.el == vimc_pkg::VIMC_EL_USER |=> rsp.result == vimc_pkg::VIMC_RES_UNDEF)
    else $error("user access not undefined"); // R22
  a_hyp_trap: assert property (@(posedge clk) disable iff (!rst_sync_reg)
    sel_any && at_hyp && !sre_hyp |=> rsp.result == vimc_pkg::VIMC_RES_TRAP
                                       && rsp.trap_class == 6'h18)
    else $error("hypervisor trap missing"); // R22
  a_bp0_clamp: assert property (@(posedge clk) disable iff (!rst_sync_reg)
    do_write |=> bp0_reg >= bp0_min)
    else $error("group zero point below minimum"); // R12
  a_ack_spurious: assert property (@(posedge clk) disable iff (!rst_sync_reg)
    pend_group_one && !ack_reg |-> ack_id == 16'h03FE)
    else $error("ack id not spurious"); // R19

endmodule

/* vimc_core_model.sv */
`timescale 1ns/1ps

// Core side: issues one system-register access at a time
module vimc_core_model (
  input  wire logic                clk,
  output vimc_pkg::vimc_req_t      req,
  input  wire vimc_pkg::vimc_rsp_t rsp
);

  initial req = '0;

  // Drive after a falling edge, drop valid once the taking edge has passed
  task automatic access(input logic wr, input logic [2:0] op2, input vimc_pkg::vimc_el_t el,
                        input logic sec, input logic [63:0] wd, input logic [3:0] crm,
                        output vimc_pkg::vimc_rsp_t r);
    r = '0;
    @(negedge clk);
    req = {1'b1, wr, vimc_pkg::OP0_SEL, vimc_pkg::OP1_SEL, vimc_pkg::CRN_SEL, crm, op2, el, sec, wd};
    // Bounded wait, a missing answer comes back with valid low
    for (int i = 0; i < 4; i++) begin
      @(negedge clk);
      req.valid = 1'b0;
      if (rsp.valid === 1'b1) begin
        r = rsp;
        break;
      end
    end
  endtask

endmodule

/* virtual_irq_maintenance_ctrl_tb.sv */
`timescale 1ns/1ps

// Core model drives the register port, the bench drives the side inputs
module virtual_irq_maintenance_ctrl_tb;
  localparam logic [2:0]         PB  = 3'h4;
  localparam logic [2:0]         MN  = 3'h7 - PB - 3'h1;
  localparam logic [2:0]         ST  = vimc_pkg::OP2_STATUS;
  localparam logic [2:0]         CT  = vimc_pkg::OP2_CONTROL;
  localparam vimc_pkg::vimc_el_t HYP = vimc_pkg::VIMC_EL_HYP;
  logic                clk;
  logic                resetn;
  vimc_pkg::vimc_req_t req;
  vimc_pkg::vimc_rsp_t rsp, r;
  vimc_pkg::vimc_hyp_t hyp;
  logic [31:0]         lr_state;
  logic [15:0]         eoi_st, pend_id, ack_id;
  logic                sre_hyp, sre_mon, nest, nest_mem, pend_valid, pend_g1;
  logic [7:0]          pend_prio;
  logic                g_rd, g_wr, maint_irq, virq, vfiq, eoi_deact, dir_act;
  logic [2:0]          g_wd, g_rdata;
  logic [8:0]          tbl [6];
  logic [31:0]         lr_pat [4];
  logic [63:0]         e;
  int                  error_cnt, n_checks;

  // 50 MHz clock
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  vimc_core_model core_u (.clk(clk), .req(req), .rsp(rsp));

  vimc_ctrl #(.PREEMPT_BITS(PB), .SRE_FIXED(1'b0)) dut_u (
    .clk(clk), .resetn(resetn), .req(req), .rsp(rsp), .hyp(hyp), .lr_state(lr_state),
    .per_entry_eoi_status(eoi_st), .sre_hyp(sre_hyp), .sre_mon(sre_mon), .nested_en(nest),
    .nested_mem_en(nest_mem), .pend_valid(pend_valid), .pend_priority(pend_prio),
    .pend_group_one(pend_g1), .pend_id(pend_id), .guest_bp1_rd(g_rd), .guest_bp1_wr(g_wr),
    .guest_bp1_wdata(g_wd), .maint_irq(maint_irq), .virq(virq), .vfiq(vfiq), .ack_id(ack_id),
    .guest_bp1_rdata(g_rdata), .eoi_deactivates(eoi_deact), .deactivate_reg_active(dir_act));

  task automatic chk(input string nm, input logic [63:0] exp, input logic [63:0] got);
    n_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("FAIL %s expected %h seen %h", nm, exp, got);
    end
  endtask

  // Single exit, also taken when an answer never arrives
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  task automatic acc(input logic wr, input logic [2:0] op2, input vimc_pkg::vimc_el_t el,
                     input logic sec, input logic [63:0] wd);
    core_u.access(wr, op2, el, sec, wd, vimc_pkg::CRM_SEL, r);
    if (r.valid !== 1'b1) begin
      error_cnt++;
      $display("FAIL answer expected 1 seen %b", r.valid);
      give_verdict();
    end
  endtask

  task automatic rd(input logic [2:0] op2, input logic [63:0] exp, input string nm);
    acc(1'b0, op2, HYP, 1'b0, 64'h0000_0000_0000_0000);
    chk(nm, exp, r.rdata);
  endtask

  // Pending interrupt applied, then the interrupt, ack, deactivation and guest point outputs compared as one word
  task automatic outs(input logic [7:0] prio, input logic g1, input logic [22:0] exp);
    pend_prio = prio;
    pend_g1 = g1;
    #1;
    chk("outputs", exp, {virq, vfiq, ack_id, eoi_deact, dir_act, g_rdata});
  endtask

  task automatic gw(input logic [2:0] d);
    g_wd = d;
    g_wr = 1'b1;
    @(negedge clk);
    g_wr = 1'b0;
  endtask

  // Flags worked out from the live inputs and the last enables written (e)
  function automatic logic [63:0] exp_st();
    int pend;
    int live;
    pend = 0;
    live = 0;
    for (int i = 0; i < 16; i++) begin
      pend += lr_state[2*i];
      live += (lr_state[2*i+:2] != 2'b00);
    end
    return {56'h0, hyp.grp_one_off_irq_en & ~e[1], hyp.grp_one_on_irq_en & e[1],
            hyp.grp_zero_off_irq_en & ~e[0], hyp.grp_zero_on_irq_en & e[0],
            hyp.none_pending_irq_en & (pend == 0),
            hyp.missing_entry_irq_en & (|hyp.deactivation_miss_counter),
            hyp.list_low_irq_en & (live <= 1), |eoi_st};
  endfunction

  initial begin
    error_cnt = 0;
    n_checks = 0;
    resetn = 1'b0;
    hyp = '0;
    lr_state = '0;
    eoi_st = '0;
    {sre_hyp, sre_mon, nest, nest_mem} = 4'b1100;
    {pend_valid, pend_g1, pend_prio, pend_id} = {2'b00, 8'h00, 16'h0033};
    {g_rd, g_wr, g_wd} = {2'b10, 3'h0};
    // el, nested, memory, sre hyp, sre mon, outcome, to monitor
    tbl = '{9'b00_0011_01_0, 9'b01_0011_01_0, 9'b01_1011_10_0, 9'b01_1111_11_0,
            9'b10_0001_10_0, 9'b11_0010_10_1};
    lr_pat = '{32'h0000_0000, 32'h0000_0001, 32'h0000_000A, 32'h4000_0001};
    repeat (8) @(negedge clk);
    resetn = 1'b1;
    repeat (3) @(negedge clk);
    rd(ST, 64'h0, "status after reset");
    rd(CT, 64'h0, "control after reset");
    chk("maint_irq idle", 1'b0, maint_irq);
    $display("test reset done");

    acc(1'b1, CT, HYP, 1'b0, 64'hFFFF_FFFF_FFFF_FFFF);
    rd(CT, 64'h0000_0000_FFFC_021F, "control all ones");
    acc(1'b1, CT, HYP, 1'b0, 64'h0);
    rd(CT, {32'h0, 8'h00, MN, MN + 3'h1, 18'h0}, "nonsecure clamp");
    acc(1'b1, CT, HYP, 1'b1, 64'h0);
    rd(CT, {32'h0, 8'h00, MN, MN, 18'h0}, "secure clamp");
    acc(1'b1, ST, HYP, 1'b0, 64'h0000_0000_0000_00FF);
    chk("status write result", vimc_pkg::VIMC_RES_OK, r.result);
    rd(ST, 64'h0, "status after write");
    $display("test control fields done");

    // Injected top-pending stays up; flags look at list entries only
    pend_valid = 1'b1;
    for (int k = 0; k < 8; k++) begin
      hyp = (k < 6) ? {7'h7F, 4'h0, k[0]} : {7'h00, 5'h01};
      lr_state = lr_pat[k % 4];
      eoi_st = k[2] ? 16'h8000 : 16'h0000;
      e = {62'h0, 2'(k >> 1)};
      acc(1'b1, CT, HYP, 1'b0, e);
      rd(ST, exp_st(), "status flags");
      chk("maint_irq", |exp_st(), maint_irq);
    end
    $display("test status flags done");

    e = {32'h0, 8'h00, MN, MN + 3'h1, 16'h0, 2'b11};
    for (int k = 0; k < 6; k++) begin
      {nest, nest_mem, sre_hyp, sre_mon} = tbl[k][6:3];
      acc(1'b1, CT, vimc_pkg::vimc_el_t'(tbl[k][8:7]), 1'b0, 64'hFFFF_FFFF_FFFF_FFFF);
      chk("outcome", tbl[k][2:1], r.result);
      chk("trap to monitor", tbl[k][0], r.trap_to_mon);
      if (tbl[k][2:1] == 2'b10) chk("trap class", 6'h18, r.trap_class);
      if (tbl[k][2:1] == 2'b11) chk("redirect offset", 12'h4C8, r.redirect_ofs);
    end
    {nest, nest_mem, sre_hyp, sre_mon} = 4'b0011;
    rd(CT, e, "control after refused writes");
    core_u.access(1'b0, ST, HYP, 1'b0, 64'h0, 4'hA, r);
    chk("stray selector answer", 1'b0, r.valid);
    $display("test access outcomes done");

    acc(1'b1, CT, HYP, 1'b0, 64'h0000_0000_80F0_020B);
    outs(8'h7F, 1'b0, {2'b01, 16'h0033, 2'b01, 3'h4});
    outs(8'h80, 1'b0, {2'b00, 16'h0033, 2'b01, 3'h4});
    outs(8'h7F, 1'b1, {2'b10, 16'h03FE, 2'b01, 3'h4});
    acc(1'b1, CT, HYP, 1'b0, 64'h0000_0000_80F4_0017);
    rd(CT, 64'h0000_0000_80F4_0017, "hyp group one point");
    outs(8'h7F, 1'b1, {2'b10, 16'h0033, 2'b10, 3'h7});
    outs(8'h7F, 1'b0, {2'b10, 16'h0033, 2'b10, 3'h7});
    gw(3'h0);
    rd(CT, 64'h0000_0000_80F4_0017, "guest write ignored");
    acc(1'b1, CT, HYP, 1'b0, 64'h0000_0000_80F4_0004);
    outs(8'h7F, 1'b0, {2'b00, 16'h0033, 2'b10, 3'h5});
    outs(8'h7F, 1'b1, {2'b00, 16'h0033, 2'b10, 3'h5});
    g_rd = 1'b0;
    outs(8'h7F, 1'b1, {2'b00, 16'h0033, 2'b10, 3'h0});
    g_rd = 1'b1;
    gw(3'h0);
    rd(CT, {32'h0, 8'h80, 3'h7, MN + 3'h1, 18'h0_0004}, "guest write clamp");
    $display("test guest outputs done");
    give_verdict();
  end

endmodule
